//--- rtl/dts_defines.vh
`ifndef DTS_DEFINES_VH
`define DTS_DEFINES_VH
// ****************************************
// timing
// ****************************************
`define DTS_CLK_HZ         20000000
`define DTS_TICK_US        250
`define DTS_TICK_CYC       ((`DTS_CLK_HZ / 1000000) * `DTS_TICK_US)
`define DTS_SLOW_MS        4
`define DTS_SLOW_TICKS     ((`DTS_SLOW_MS * 1000) / `DTS_TICK_US)
`define DTS_LOCK_S         1
`define DTS_LOCK_TICKS     ((`DTS_LOCK_S * 1000000) / `DTS_TICK_US)
`define DTS_INJ_TICKS_PER_DS ((100000) / `DTS_TICK_US)
// ****************************************
// encodings
// ****************************************
`define DTS_TQ_SPEED       3'h0
`define DTS_TQ_TORQUE      3'h1
`define DTS_TQ_OVERRIDE    3'h2
`define DTS_TQ_COILER      3'h3
`define DTS_TQ_FEEDFWD     3'h4
`define DTS_SM_COAST       3'h0
`define DTS_SM_RAMP        3'h1
`define DTS_SM_NORAMP      3'h2
`define DTS_SM_RAMP_INJ    3'h2
`define DTS_SM_INJ_ZSD     3'h3
`define DTS_SM_INJ_TIMED   3'h4
`define DTS_SM_DISABLE     3'h5
`define DTS_COIL_SPD       16'sh0005
`endif

//--- rtl/dts_sequencer.v
`timescale 1ns/1ps
`include "dts_defines.vh"
module dts_sequencer (
  // clock and reset
  input  wire               ref_clk,
  input  wire               rst,
  // configuration
  input  wire               closed_loop,
  input  wire [2:0]         torque_mode_selector,
  input  wire [2:0]         stop_mode_selector,
  input  wire               offset_enable,
  input  wire               fast_ref_sample,
  input  wire               drive_enable_setting,
  input  wire [10:0]        injection_level_setting,
  input  wire [7:0]         injection_time_setting,
  input  wire signed [15:0] max_frequency_limit,
  input  wire signed [15:0] pi_kp,
  input  wire signed [15:0] pi_ki,
  // run and pins
  input  wire               run_cmd,
  input  wire               safe_off_n,
  input  wire               overspeed,
  input  wire               ramp_at_zero,
  input  wire               low_speed_det,
  // operands
  input  wire signed [15:0] torque_reference_setting,
  input  wire signed [15:0] torque_offset_setting,
  input  wire signed [15:0] speed_loop_out,
  input  wire signed [15:0] feed_forward,
  input  wire signed [15:0] final_speed_demand,
  input  wire signed [15:0] measured_speed,
  input  wire signed [15:0] current_demand,
  input  wire signed [15:0] current_feedback,
  // outputs
  output reg                inverter_enable,
  output reg                ramp_bypass,
  output reg                ramp_preload,
  output reg  signed [15:0] ramp_preload_value,
  output reg                ramp_stop,
  output reg                dc_inject,
  output reg                lf_inject,
  output reg  [10:0]        inject_level,
  output reg  signed [15:0] torque_demand,
  output reg  signed [15:0] speed_max_limit,
  output reg  signed [15:0] speed_min_limit,
  output reg                speed_limit_active,
  output reg  signed [15:0] freq_reference,
  output reg                ready_state,
  output reg                trip_latched,
  output reg                lockout
);
  // sequencer state codes
  localparam ST_READY = 3'h0, ST_RUN  = 3'h1, ST_DECEL = 3'h2, ST_INJ = 3'h3,
             ST_HOLD  = 3'h4, ST_LOCK = 3'h5, ST_TRIP  = 3'h6;
  reg [2:0]         state_reg, state_next;
  reg [12:0]        tick_cnt_reg;
  reg               tick, phase_done;
  reg [4:0]         slow_cnt_reg;
  // 17 bits: the longest injection time is 102000 ticks
  reg [16:0]        phase_cnt_reg;
  reg [2:0]         sm_latch_reg;
  reg               en_q1_reg, en_q2_reg, en_q3_reg, en_reg;
  reg               run_q1_reg, run_q2_reg, run_q3_reg, run_reg;
  reg               ov_q1_reg, ov_q2_reg, ov_q3_reg, ov_reg;
  reg signed [15:0] tref_reg;
  reg signed [31:0] integ_reg;
  reg signed [16:0] tres, tsum;
  reg signed [15:0] tres_sat;
  reg signed [31:0] perr, pi_sum;
  wire              enable_ok;
  wire [31:0]       inj_ticks;
  assign enable_ok = drive_enable_setting & en_reg;
  // injection time in 0.1s units, kept at full width so 25s cannot wrap
  assign inj_ticks = injection_time_setting * `DTS_INJ_TICKS_PER_DS;
  // ****************************************
  // pin synchronisers, second and third agree
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      {en_q1_reg, en_q2_reg, en_q3_reg, en_reg} <= 4'h0;
      {run_q1_reg, run_q2_reg, run_q3_reg, run_reg} <= 4'h0;
      {ov_q1_reg, ov_q2_reg, ov_q3_reg, ov_reg} <= 4'h0;
    end else begin
      en_q1_reg  <= safe_off_n;
      en_q2_reg  <= en_q1_reg;
      en_q3_reg  <= en_q2_reg;
      run_q1_reg <= run_cmd;
      run_q2_reg <= run_q1_reg;
      run_q3_reg <= run_q2_reg;
      ov_q1_reg  <= overspeed;
      ov_q2_reg  <= ov_q1_reg;
      ov_q3_reg  <= ov_q2_reg;
      if (en_q2_reg == en_q3_reg)
        en_reg <= en_q3_reg;
      if (run_q2_reg == run_q3_reg)
        run_reg <= run_q3_reg;
      if (ov_q2_reg == ov_q3_reg)
        ov_reg <= ov_q3_reg;
    end
  end
  // ****************************************
  // control tick and reference sampling
  // ****************************************
  // one 250us tick drives all timers; 4ms is 16 ticks
  always @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_reg <= 13'h0;
      tick         <= 1'b0;
      slow_cnt_reg <= 5'h0;
      tref_reg     <= 16'sh0000;
    end else begin
      tick <= (tick_cnt_reg == `DTS_TICK_CYC - 1);
      tick_cnt_reg <= (tick_cnt_reg == `DTS_TICK_CYC - 1) ? 13'h0 :
                      tick_cnt_reg + 13'h1;
      if (tick) begin
        slow_cnt_reg <= (slow_cnt_reg == `DTS_SLOW_TICKS - 1) ? 5'h0 :
                        slow_cnt_reg + 5'h1;
        // fast path only for closed loop analog voltage source
        if (fast_ref_sample && closed_loop)
          tref_reg <= torque_reference_setting;
        else if (slow_cnt_reg == `DTS_SLOW_TICKS - 1)
          tref_reg <= torque_reference_setting;
      end
    end
  end
  // ****************************************
  // torque demand formation
  // ****************************************
  always @* begin
    tsum = {speed_loop_out[15], speed_loop_out}
         + {feed_forward[15], feed_forward};
    tres = {tref_reg[15], tref_reg} + (offset_enable ?
           {torque_offset_setting[15], torque_offset_setting} : 17'sh00000);
    // saturate resultant so an overflow cannot flip the sign
    if (tres > 17'sh07fff)
      tres_sat = 16'sh7fff;
    else if (tres < -17'sh08000)
      tres_sat = -16'sh8000;
    else
      tres_sat = tres[15:0];
    perr   = current_demand - current_feedback;
    pi_sum = perr * pi_kp + integ_reg;
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      torque_demand      <= 16'sh0000;
      speed_max_limit    <= 16'sh0000;
      speed_min_limit    <= 16'sh0000;
      speed_limit_active <= 1'b0;
      freq_reference     <= 16'sh0000;
      integ_reg          <= 32'sh0;
    end else begin
      speed_limit_active <= 1'b0;
      speed_max_limit    <= 16'sh0000;
      speed_min_limit    <= 16'sh0000;
      if (!closed_loop) begin
        torque_demand <= 16'sh0000;
        if (torque_mode_selector == `DTS_TQ_TORQUE &&
            state_reg == ST_RUN) begin
          if (tick)
            integ_reg <= integ_reg + perr * pi_ki;
          if (pi_sum > max_frequency_limit) // signed, sign-extended
            freq_reference <= max_frequency_limit;
          else if (pi_sum < -max_frequency_limit)
            freq_reference <= -max_frequency_limit;
          else
            freq_reference <= pi_sum[15:0];
        end else begin
          integ_reg      <= 32'sh0;
          freq_reference <= 16'sh0000;
        end
      end else begin
        freq_reference <= 16'sh0000;
        case (torque_mode_selector)
          `DTS_TQ_SPEED:
            torque_demand <= speed_loop_out;
          `DTS_TQ_TORQUE:
            torque_demand <= tres_sat;
          `DTS_TQ_OVERRIDE: begin
            if (tres_sat >= 0)
              torque_demand <= (speed_loop_out < 0) ? 16'sh0000 :
                (speed_loop_out > tres_sat) ? tres_sat :
                speed_loop_out;
            else
              torque_demand <= (speed_loop_out > 0) ? 16'sh0000 :
                (speed_loop_out < tres_sat) ? tres_sat :
                speed_loop_out;
          end
          `DTS_TQ_COILER: begin
            torque_demand      <= tres_sat;
            speed_limit_active <= 1'b1;
            if (final_speed_demand >= 0) begin
              speed_max_limit <= final_speed_demand;
              speed_min_limit <= -`DTS_COIL_SPD;
            end else begin
              speed_min_limit <= final_speed_demand;
              speed_max_limit <= `DTS_COIL_SPD;
            end
          end
          `DTS_TQ_FEEDFWD: begin
            if (tsum > 17'sh07fff)
              torque_demand <= 16'sh7fff;
            else if (tsum < -17'sh08000)
              torque_demand <= -16'sh8000;
            else
              torque_demand <= tsum[15:0];
          end
          default:
            torque_demand <= speed_loop_out;
        endcase
      end
    end
  end
  // ****************************************
  // stop sequencer
  // ****************************************
  always @* begin
    phase_done = 1'b0;
    state_next = state_reg;
    case (state_reg)
      ST_READY:
        if (run_reg && enable_ok)
          state_next = ST_RUN;
      ST_RUN:
        if (!enable_ok)
          state_next = ST_LOCK;
        else if (!run_reg) begin
          if (closed_loop)
            state_next = (sm_latch_reg == `DTS_SM_COAST) ? ST_READY :
                         ST_DECEL;
          else case (stop_mode_selector)
            `DTS_SM_COAST:     state_next = ST_LOCK;
            `DTS_SM_DISABLE:   state_next = ST_READY;
            `DTS_SM_INJ_ZSD:   state_next = ST_DECEL;
            `DTS_SM_INJ_TIMED: state_next = ST_INJ;
            default:           state_next = ST_DECEL;
          endcase
        end
      ST_DECEL: begin
        if (!enable_ok)
          state_next = ST_LOCK;
        else if (closed_loop) begin
          if (ramp_at_zero)
            state_next = ST_READY;
          else if (run_reg && sm_latch_reg != `DTS_SM_NORAMP)
            state_next = ST_RUN;
        end else if (sm_latch_reg == `DTS_SM_INJ_ZSD) begin
          if (low_speed_det)
            state_next = ST_INJ;
        end else if (ramp_at_zero)
          state_next = (sm_latch_reg == `DTS_SM_RAMP_INJ) ? ST_INJ :
                       ST_HOLD;
        else if (run_reg)
          state_next = ST_RUN;
      end
      ST_INJ: begin
        phase_done = tick && (phase_cnt_reg >= inj_ticks);
        if (!enable_ok)
          state_next = ST_LOCK;
        else if (phase_done)
          state_next = ST_READY;
      end
      ST_HOLD: begin
        phase_done = tick && (phase_cnt_reg >= `DTS_LOCK_TICKS - 1);
        if (!enable_ok)
          state_next = ST_LOCK;
        else if (run_reg)
          state_next = ST_RUN;
        else if (phase_done)
          state_next = ST_READY;
      end
      ST_LOCK: begin
        phase_done = tick && (phase_cnt_reg >= `DTS_LOCK_TICKS - 1);
        if (phase_done)
          state_next = ST_READY;
      end
      ST_TRIP: state_next = ST_TRIP;
      default: state_next = ST_READY;
    endcase
    if (ov_reg)
      state_next = ST_TRIP;
  end
  // state, phase counter and stop mode latch
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg     <= ST_READY;
      phase_cnt_reg <= 17'h0;
      sm_latch_reg  <= `DTS_SM_RAMP;
    end else begin
      state_reg <= state_next;
      // counter restarts on every phase entry
      if (state_next != state_reg)
        phase_cnt_reg <= 17'h0;
      else if (tick && phase_cnt_reg != 17'h1ffff)
        phase_cnt_reg <= phase_cnt_reg + 17'h1;
      if (state_reg == ST_RUN)
        sm_latch_reg <= stop_mode_selector;
    end
  end
  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      inverter_enable    <= 1'b0;
      ramp_bypass        <= 1'b0;
      ramp_preload       <= 1'b0;
      ramp_preload_value <= 16'sh0000;
      ramp_stop          <= 1'b0;
      dc_inject          <= 1'b0;
      lf_inject          <= 1'b0;
      inject_level       <= 11'h0;
      ready_state        <= 1'b1;
      trip_latched       <= 1'b0;
      lockout            <= 1'b0;
    end else begin
      inverter_enable <= state_next != ST_READY && state_next != ST_LOCK &&
                         state_next != ST_TRIP;
      ramp_bypass <= closed_loop && state_next == ST_RUN &&
                     torque_mode_selector >= `DTS_TQ_TORQUE &&
                     torque_mode_selector <= `DTS_TQ_COILER;
      // preload pulse on the run to ramp-stop changeover
      ramp_preload <= ramp_bypass && state_next == ST_DECEL &&
                      sm_latch_reg == `DTS_SM_RAMP;
      if (state_reg == ST_RUN)
        ramp_preload_value <= measured_speed;
      ramp_stop <= state_next == ST_DECEL &&
                   (closed_loop ? sm_latch_reg == `DTS_SM_RAMP :
                    sm_latch_reg != `DTS_SM_INJ_ZSD);
      lf_inject <= !closed_loop && state_next == ST_DECEL &&
                   sm_latch_reg == `DTS_SM_INJ_ZSD;
      dc_inject <= state_next == ST_INJ;
      inject_level <= injection_level_setting;
      ready_state  <= state_next == ST_READY;
      trip_latched <= state_next == ST_TRIP;
      lockout      <= state_next == ST_LOCK;
    end
  end
endmodule

//--- verification/dts_sequencer_sva.sv
`timescale 1ns/1ps
// ****************************************
// stop and torque checker
// ****************************************
module dts_sequencer_chk (
  // clock and reset
  input logic               ref_clk,
  input logic               rst,
  // configuration and pins
  input logic               closed_loop,
  input logic [2:0]         torque_mode_selector,
  input logic [2:0]         stop_mode_selector,
  input logic               drive_enable_setting,
  input logic signed [15:0] max_frequency_limit,
  input logic               run_cmd,
  input logic signed [15:0] speed_loop_out,
  input logic signed [15:0] feed_forward,
  input logic signed [15:0] measured_speed,
  // watched outputs
  input logic               inverter_enable,
  input logic               ramp_preload,
  input logic signed [15:0] ramp_preload_value,
  input logic signed [15:0] torque_demand,
  input logic signed [15:0] freq_reference,
  input logic               ready_state,
  input logic               trip_latched,
  input logic               lockout
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // torque forming, one cycle after operands
  a_speed_torque: assert property (
    $past(closed_loop) && !$past(rst) && $past(torque_mode_selector) == 3'h0
    |-> torque_demand == $past(speed_loop_out))
    else $error("speed mode torque off");
  a_feed_fwd: assert property (
    $past(closed_loop) && !$past(rst) && $past(torque_mode_selector) == 3'h4
    |-> torque_demand == $past(speed_loop_out) + $past(feed_forward))
    else $error("feed forward sum off");
  // the clamp keeps the sign of the speed output, or gives zero
  a_override_sign: assert property (
    $past(closed_loop) && !$past(rst) && $past(torque_mode_selector) == 3'h2
    |-> torque_demand == 16'sh0000 ||
        (torque_demand < 0) == ($past(speed_loop_out) < 0))
    else $error("override torque sign off");
  a_freq_clamp: assert property (
    freq_reference <= max_frequency_limit &&
    freq_reference >= -max_frequency_limit)
    else $error("frequency out of range");
  // stop sequencing
  a_preload_val: assert property (
    ramp_preload |-> ramp_preload_value == $past(measured_speed))
    else $error("preload value off");
  a_preload_pulse: assert property (
    ramp_preload |=> !ramp_preload)
    else $error("preload not a pulse");
  a_disable_fast: assert property (
    !closed_loop && stop_mode_selector == 3'h5 && inverter_enable &&
    $fell(run_cmd) |-> ##[1:8] !inverter_enable)
    else $error("disable stop slow");
  a_enable_drop: assert property (
    inverter_enable && $fell(drive_enable_setting)
    |-> ##[1:4] (lockout && !inverter_enable))
    else $error("enable loss not locked");
  a_lock_off: assert property (lockout |-> !inverter_enable)
    else $error("enabled while locked");
  a_trip_hold: assert property (trip_latched |=> trip_latched)
    else $error("trip released");
  a_trip_off: assert property (trip_latched |-> !inverter_enable)
    else $error("enabled while tripped");
  a_ready_off: assert property (ready_state |-> !inverter_enable)
    else $error("enabled while ready");
endmodule

bind dts_sequencer dts_sequencer_chk dts_sequencer_chk_inst (.*);

//--- verification/dts_power_stage.sv
`timescale 1ns/1ps
// ****************************************
// power stage and motor model
// ****************************************
module dts_power_stage (
  // clock
  input  logic               ref_clk,
  // stage controls
  input  logic               inverter_enable,
  input  logic               ramp_stop,
  input  logic               lf_inject,
  // motor feedback
  output logic               ramp_at_zero,
  output logic               low_speed_det,
  output logic signed [15:0] measured_speed
);
  logic signed [15:0] spd_reg = 16'sh0064;
  // speed falls one step a cycle while braking, so stops take ~100 cycles
  always @(posedge ref_clk) begin
    if ((ramp_stop || lf_inject) && spd_reg != 0)
      spd_reg <= spd_reg - 16'sh0001;
    else if (inverter_enable && !ramp_stop && !lf_inject)
      spd_reg <= 16'sh0064;
  end
  assign measured_speed = spd_reg;
  assign ramp_at_zero   = ramp_stop && spd_reg == 0;
  assign low_speed_det  = lf_inject && spd_reg < 16'sh0008;
endmodule

//--- verification/dts_sequencer_tb.sv
`timescale 1ns/1ps
// ****************************************
// sequencer testbench
// ****************************************
module dts_sequencer_tb;
  // stimulus
  logic ref_clk = 0, rst = 1, closed_loop = 1, offset_enable = 1;
  logic fast_ref_sample = 1, drive_enable_setting = 1, run_cmd = 0;
  logic safe_off_n = 1, overspeed = 0;
  logic [2:0]  torque_mode_selector = 3'h0, stop_mode_selector = 3'h1;
  logic [10:0] injection_level_setting = 11'h3e8;
  logic [7:0]  injection_time_setting = 8'h01;
  logic signed [15:0] max_frequency_limit = 16'sh0100;
  logic signed [15:0] pi_kp = 16'sh7fff, pi_ki = 16'sh0000;
  logic signed [15:0] torque_reference_setting = 16'sh0040;
  logic signed [15:0] torque_offset_setting = 16'sh0010;
  logic signed [15:0] speed_loop_out = 16'sh0030, feed_forward = 16'sh0005;
  logic signed [15:0] final_speed_demand = 16'sh0200;
  logic signed [15:0] current_demand = 16'sh1000;
  logic signed [15:0] current_feedback = 16'sh0000;
  // observed
  logic ramp_at_zero, low_speed_det, inverter_enable, ramp_bypass;
  logic ramp_preload, ramp_stop, dc_inject, lf_inject, speed_limit_active;
  logic ready_state, trip_latched, lockout;
  logic [10:0] inject_level;
  logic signed [15:0] measured_speed, ramp_preload_value, torque_demand;
  logic signed [15:0] speed_max_limit, speed_min_limit, freq_reference;
  int n_errors = 0, checks = 0;

  dts_sequencer dts_sequencer_inst (.*);
  dts_power_stage dts_power_stage_inst (.*);

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // inputs move 1 ns after the edge so no race with sampling
  task tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task rstd;
    rst = 1;
    tick(5);
    rst = 0;
    tick(1);
  endtask
  // pins pass a 3-stage sync, so allow 8 cycles
  task run(input logic v);
    run_cmd = v;
    tick(8);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog, well past the ~21k cycles the tests need
  initial begin
    #(50 * 60000);
    n_errors++;
    test_done;
  end

  // main sequence
  initial begin
    rstd;
    chk(ready_state, 1'b1);
    chk(inverter_enable, 1'b0);
    chk(trip_latched, 1'b0);
    tick(5100); // first fast reference sample
    chk(torque_demand, 16'sh0030);
    torque_mode_selector = 3'h4;
    tick(2);
    chk(torque_demand, 16'sh0035);
    torque_mode_selector = 3'h2;
    speed_loop_out = 16'sh0090;
    tick(2);
    chk(torque_demand, 16'sh0050);
    speed_loop_out = -16'sh0030;
    tick(2);
    chk(torque_demand, 16'sh0000);
    torque_mode_selector = 3'h1;
    run(1);
    chk(inverter_enable, 1'b1);
    chk(ramp_bypass, 1'b1);
    chk(torque_demand, 16'sh0050);
    torque_mode_selector = 3'h3;
    tick(2);
    chk(speed_max_limit, 16'sh0200);
    chk(speed_limit_active, 1'b1);
    torque_reference_setting = -16'sh0040;
    tick(5100);
    chk(speed_min_limit, -16'sh0005);
    final_speed_demand = -16'sh0200;
    tick(2);
    chk(speed_min_limit, -16'sh0200);
    torque_reference_setting = 16'sh0040;
    tick(5100);
    chk(speed_max_limit, 16'sh0005);
    torque_mode_selector = 3'h1;
    run(0);
    repeat (300) if (!ready_state) tick(1);
    chk(ready_state, 1'b1);
    chk(ramp_bypass, 1'b0);
    chk(ramp_preload_value, 16'sh0064);
    run(1);
    overspeed = 1;
    tick(8);
    chk(trip_latched, 1'b1);
    chk(inverter_enable, 1'b0);
    overspeed = 0;
    tick(8);
    chk(trip_latched, 1'b1);
    run(0);
    rstd;
    // open loop current control, then disable stop
    closed_loop = 0;
    stop_mode_selector = 3'h5;
    run(1);
    tick(5100);
    chk(freq_reference, 16'sh0100);
    run(0);
    chk(inverter_enable, 1'b0);
    run(1);
    chk(inverter_enable, 1'b1);
    drive_enable_setting = 0;
    tick(8);
    chk(lockout, 1'b1);
    chk(inverter_enable, 1'b0);
    drive_enable_setting = 1;
    tick(8);
    chk(inverter_enable, 1'b0);
    run(0);
    rstd;
    torque_mode_selector = 3'h0;
    stop_mode_selector = 3'h0;
    run(1);
    run(0);
    chk(inverter_enable, 1'b0);
    chk(lockout, 1'b1);
    run(1);
    chk(inverter_enable, 1'b0);
    run(0);
    rstd;
    stop_mode_selector = 3'h4;
    run(1);
    run(0);
    chk(dc_inject, 1'b1);
    chk(inject_level, 16'h03e8);
    run(1);
    chk(ready_state, 1'b0);
    chk(dc_inject, 1'b1);
    run(0);
    rstd;
    stop_mode_selector = 3'h3;
    run(1);
    run(0);
    chk(lf_inject, 1'b1);
    repeat (300) if (!dc_inject) tick(1);
    chk(dc_inject, 1'b1);
    chk(lf_inject, 1'b0);
    run(0);
    rstd;
    // open loop ramp stop: ramp to zero, then hold enabled
    stop_mode_selector = 3'h1;
    run(1);
    chk(freq_reference, 16'sh0000);
    run(0);
    chk(ramp_stop, 1'b1);
    repeat (300) if (ramp_stop) tick(1);
    chk(ramp_stop, 1'b0);
    chk(inverter_enable, 1'b1);
    chk(ready_state, 1'b0);
    test_done;
  end
endmodule
